//--- fsiu_pkg.sv
// Purpose: Shared constants, types and helpers of the fourteen source interrupt unit.
// Assumes: Byte addressed AXI4-Lite register window, 8-bit registers in the low byte.
// Notes:   Arbitration index 0 is the first source to win inside one level.
//
// Operation
// - Fourteen sources: two pins, timers, serial, port1.
// - Each source gated by its own enable.
// - Main enable bit 7 gates every source's request to the core.
// - Main enable bits map t2,ser,t1,x1,t0,x0.
// - Extended enable: 0 disables, 1 enables.
// - Port1 inputs level sensitive, wake power-down.
// - Port1 active level selectable per pin.
// - Hardware sets port1 flags, only software clears.
// - Flag left set re-raises after service ends.
// - Flag bits 7..0 hold inputs nine..two.
// - Higher priority level beats lower level.
// - Fixed order resolves ties within one level.
// - Each source has its own vector address.
// - Port1 pins zero..seven are inputs two..nine.
// - Interrupts keep running and end idle.
// - All unit registers reset to zero.

package fsiu_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam int         NSRC         = 14;
    localparam logic [7:0] ADDR_IE_MAIN = 8'hA8;
    localparam logic [7:0] ADDR_IE_EXT  = 8'hAC;
    localparam logic [7:0] ADDR_PRIO_LO = 8'hB8;
    localparam logic [7:0] ADDR_PRIO_HI = 8'hBC;
    localparam logic [7:0] ADDR_FLAGS   = 8'hC0;
    localparam logic [7:0] ADDR_POL     = 8'hC4;
    localparam logic [7:0] ADDR_STATUS  = 8'hC8;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // Main enable field positions
    localparam int GATE_BIT = 7;
    localparam int EN_T2    = 5;
    localparam int EN_SER   = 4;
    localparam int EN_T1    = 3;
    localparam int EN_X1    = 2;
    localparam int EN_T0    = 1;
    localparam int EN_X0    = 0;

    // ********************************************************************
    // Types
    // ********************************************************************
    // Request flags raised by the timer and serial logic of the core
    typedef struct packed {
        logic serial_receive_flag;
        logic serial_transmit_flag;
        logic timer0_overflow_flag;
        logic timer1_overflow_flag;
        logic timer2_overflow_flag;
        logic timer2_external_flag;
    } fsiu_src_t;

    // Request offered to the core
    typedef struct packed {
        logic        req;
        logic        level;
        logic [15:0] vector;
    } fsiu_irq_t;

    typedef struct packed {
        logic [7:0] ie_main;
        logic [7:0] ie_ext;
        logic [7:0] prio_lo;
        logic [7:0] prio_hi;
        logic [7:0] polarity;
        logic [7:0] flags;
        logic [7:0] p1_meta;
        logic [7:0] p1_sync;
        logic [1:0] x_meta;
        logic [1:0] x_sync;
        logic [1:0] in_service;
        logic [3:0] win_idx;
        fsiu_irq_t  irq;
        logic       wake_idle;
        logic       wake_pd;
        logic       aw_hold;
        logic [7:0] aw_addr;
        logic       w_hold;
        logic [7:0] w_data;
        logic       w_strb;
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } fsiu_state_t;

    // Synchronisers start at the pulled-up idle level; a zero there would
    // look like an active-low request and set every port1 flag after reset
    localparam fsiu_state_t STATE_RESET = '{p1_meta: 8'hFF, p1_sync: 8'hFF, x_meta: 2'h3,
                                            x_sync: 2'h3, default: '0};

    // Vector of each arbitration slot, slot 0 first
    localparam logic [15:0] VEC_TABLE [NSRC] = '{
        16'h0003, 16'h0023, 16'h0053, 16'h000B, 16'h005B, 16'h0013, 16'h003B,
        16'h0063, 16'h001B, 16'h002B, 16'h0043, 16'h006B, 16'h004B, 16'h0073};

    // Main bits (enable layout) and port1 bits into arbitration order
    function automatic logic [13:0] order_map(input logic [5:0] m, input logic [7:0] p);
        order_map = {p[7], p[2], p[6], p[1], m[EN_T2], m[EN_T1], p[5], p[0],
                     m[EN_X1], p[4], m[EN_T0], p[3], m[EN_SER], m[EN_X0]};
    endfunction : order_map

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ADDR_IE_MAIN) || (a == ADDR_IE_EXT) || (a == ADDR_PRIO_LO) ||
                  (a == ADDR_PRIO_HI) || (a == ADDR_FLAGS) || (a == ADDR_POL) ||
                  (a == ADDR_STATUS);
    endfunction : addr_ok

endpackage : fsiu_pkg

//--- fsiu_arbiter.sv
// Purpose: Picks the winning request from the pending set.
// Assumes: Pending and level vectors are in arbitration order.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/100ps

module fsiu_arbiter
    import fsiu_pkg::*;
(
    input  wire logic [NSRC-1:0] pend,
    input  wire logic [NSRC-1:0] lvl,
    output logic                 hit,
    output logic [3:0]           idx,
    output logic                 hlvl
);
    logic [NSRC-1:0] hi_pend;

    // High level first, then the lowest slot within the level
    always_comb begin
        hi_pend = pend & lvl;
        hit     = |pend;
        hlvl    = |hi_pend;
        idx     = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (hlvl ? hi_pend[i] : pend[i]) begin
                idx = 4'(i);
            end
        end
    end

endmodule : fsiu_arbiter

//--- fsiu_top.sv
// Purpose: Fourteen source interrupt unit with an AXI4-Lite register slave.
// Assumes: Pins are asynchronous; core flags come from logic on sys_clk.
// Notes:   One outstanding write and one outstanding read on the bus.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps

module fsiu_top
    import fsiu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_input_zero_n,
    input  wire logic        ext_input_one_n,
    input  wire logic [7:0]  port1_ext_inputs,
    input  fsiu_src_t        core_flags,
    input  wire logic        irq_ack,
    input  wire logic        irq_done,
    input  wire logic        idle_mode,
    output fsiu_irq_t        irq_out,
    output logic             wake_idle,
    output logic             wake_power_down
);

    // ********************************************************************
    // State and decode
    // ********************************************************************
    fsiu_state_t     st;
    fsiu_state_t     nx;
    logic [7:0]      p1_act;
    logic            ext0_request_flag;
    logic            ext1_request_flag;
    logic [5:0]      main_raw;
    logic [NSRC-1:0] raw_order;
    logic [NSRC-1:0] en_order;
    logic [NSRC-1:0] lvl_order;
    logic [NSRC-1:0] pend_order;
    logic            hit;
    logic [3:0]      hidx;
    logic            hlvl;
    logic            allowed;
    logic            wr_fire;
    logic            ack_take;

    // Active level per pin; the polarity bit equals the active level
    assign p1_act = ~(st.p1_sync ^ st.polarity);

    // Classic pins are active low levels
    assign ext0_request_flag = ~st.x_sync[0];
    assign ext1_request_flag = ~st.x_sync[1];

    // Raw requests in enable bit layout
    assign main_raw = {core_flags.timer2_overflow_flag | core_flags.timer2_external_flag,
                       core_flags.serial_receive_flag | core_flags.serial_transmit_flag,
                       core_flags.timer1_overflow_flag,
                       ext1_request_flag,
                       core_flags.timer0_overflow_flag,
                       ext0_request_flag};

    // Fourteen slots in tie order; port1 enable bit n-2 for input n
    assign raw_order = order_map(main_raw, st.flags);
    assign en_order  = order_map(st.ie_main[5:0], st.ie_ext);
    assign lvl_order = order_map(st.prio_lo[5:0], st.prio_hi);
    assign pend_order = raw_order & en_order;

    fsiu_arbiter u_arb (
        .pend (pend_order),
        .lvl  (lvl_order),
        .hit  (hit),
        .idx  (hidx),
        .hlvl (hlvl)
    );

    // A level may only interrupt a strictly lower level in service
    assign allowed  = hit && (hlvl ? !st.in_service[1] : (st.in_service == 2'h0));
    assign ack_take = irq_ack && st.irq.req;
    assign wr_fire  = st.aw_hold && st.w_hold && !st.bvalid;

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        nx = st;
        // Two stage synchronisers on every pin
        nx.p1_meta = port1_ext_inputs;
        nx.p1_sync = st.p1_meta;
        nx.x_meta  = {ext_input_one_n, ext_input_zero_n};
        nx.x_sync  = st.x_meta;

        // Address and data are taken in either order
        if (s_axi_awvalid && st.awready) begin
            nx.aw_hold = 1'b1;
            nx.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            nx.w_hold = 1'b1;
            nx.w_data = s_axi_wdata[7:0];
            nx.w_strb = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end
        if (wr_fire) begin
            nx.aw_hold = 1'b0;
            nx.w_hold  = 1'b0;
            nx.bvalid  = 1'b1;
            nx.bresp   = addr_ok(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            // Only lane 0 carries data; other lanes are ignored
            if (st.w_strb) begin
                unique case (st.aw_addr)
                    ADDR_IE_MAIN: nx.ie_main  = st.w_data & 8'hBF;
                    ADDR_IE_EXT:  nx.ie_ext   = st.w_data;
                    ADDR_PRIO_LO: nx.prio_lo  = st.w_data & 8'h3F;
                    ADDR_PRIO_HI: nx.prio_hi  = st.w_data;
                    ADDR_FLAGS:   nx.flags    = st.w_data;
                    ADDR_POL:     nx.polarity = st.w_data;
                    default:      nx.flags    = nx.flags;
                endcase
            end
        end
        // Set wins over a clearing write in the same cycle
        nx.flags = nx.flags | p1_act;

        // Read channel answers one cycle after the address is taken
        if (s_axi_arvalid && st.arready) begin
            nx.rvalid = 1'b1;
            nx.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                ADDR_IE_MAIN: nx.rdata = st.ie_main;
                ADDR_IE_EXT:  nx.rdata = st.ie_ext;
                ADDR_PRIO_LO: nx.rdata = st.prio_lo;
                ADDR_PRIO_HI: nx.rdata = st.prio_hi;
                ADDR_FLAGS:   nx.rdata = st.flags;
                ADDR_POL:     nx.rdata = st.polarity;
                ADDR_STATUS:  nx.rdata = {st.in_service, st.irq.level, st.irq.req, st.win_idx};
                default:      nx.rdata = REG_RESET;
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        nx.awready = !nx.aw_hold && !nx.bvalid;
        nx.wready  = !nx.w_hold && !nx.bvalid;
        nx.arready = !nx.rvalid;

        // In service levels; the end of service frees the highest one
        if (ack_take) begin
            nx.in_service[st.irq.level] = 1'b1;
        end else if (irq_done) begin
            if (st.in_service[1]) begin
                nx.in_service[1] = 1'b0;
            end else begin
                nx.in_service[0] = 1'b0;
            end
        end

        // Request to the core, dropped for one cycle on acknowledge
        nx.irq.req    = st.ie_main[GATE_BIT] && allowed && !ack_take;
        nx.irq.level  = hlvl;
        nx.irq.vector = VEC_TABLE[hidx];
        nx.win_idx    = hidx;

        // Wake signals; idle logic keeps running on sys_clk
        nx.wake_idle = idle_mode && st.irq.req;
        nx.wake_pd   = |(p1_act & st.ie_ext);
    end

    // Single state register; reset clears every field except the synchronisers, which start high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= STATE_RESET;
        end else begin
            st <= nx;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign s_axi_awready   = st.awready;
    assign s_axi_wready    = st.wready;
    assign s_axi_bvalid    = st.bvalid;
    assign s_axi_bresp     = st.bresp;
    assign s_axi_arready   = st.arready;
    assign s_axi_rvalid    = st.rvalid;
    assign s_axi_rresp     = st.rresp;
    assign s_axi_rdata     = {24'h000000, st.rdata};
    assign irq_out         = st.irq;
    assign wake_idle       = st.wake_idle;
    assign wake_power_down = st.wake_pd;

    // ********************************************************************
    // Checks
    // ********************************************************************
    logic [NSRC-1:0] en_q;
    logic [NSRC-1:0] lvl_q;
    logic [7:0]      act_q;
    logic            flag_wr_q;

    // Enable and activity seen at the edge the request was formed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            en_q      <= '0;
            lvl_q     <= '0;
            act_q     <= 8'h00;
            flag_wr_q <= 1'b0;
        end else begin
            en_q      <= en_order;
            lvl_q     <= lvl_order;
            act_q     <= p1_act;
            flag_wr_q <= wr_fire && st.w_strb && (st.aw_addr == ADDR_FLAGS);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence ack_seen_s;
        st.irq.req && irq_ack;
    endsequence

    sequence drop_s;
        !st.irq.req;
    endsequence

    sequence rd_take_s;
        s_axi_arvalid && st.arready;
    endsequence

    sequence wr_fire_s;
        st.aw_hold && st.w_hold && !st.bvalid;
    endsequence

    sequence done_high_s;
        irq_done && !ack_take && st.in_service[1];
    endsequence

    gate_off_a: assert property (!st.ie_main[GATE_BIT] |=> !st.irq.req)
        else $error("request raised while global gate clear");

    enabled_only_a: assert property (st.irq.req |-> en_q[st.win_idx])
        else $error("disabled source forwarded");

    flag_set_a: assert property (p1_act != 8'h00 |=> (st.flags & act_q) == act_q)
        else $error("active port1 level did not set its flag");

    flag_clear_a: assert property ((($past(st.flags) & ~st.flags) != 8'h00) |-> flag_wr_q)
        else $error("port1 flag cleared without a write");

    vector_map_a: assert property (st.irq.req |-> st.irq.vector == VEC_TABLE[st.win_idx])
        else $error("vector does not match winning source");

    ack_drop_a: assert property (ack_seen_s |=> drop_s ##1 (st.in_service != 2'h0))
        else $error("request not dropped or service not marked after ack");

    high_busy_a: assert property (st.in_service[1] |=> !st.irq.req)
        else $error("request raised while high level in service");

    idle_wake_a: assert property (idle_mode && st.irq.req |=> wake_idle)
        else $error("pending request did not end idle");

    pd_wake_a: assert property ((p1_act & st.ie_ext) != 8'h00 |=> wake_power_down)
        else $error("enabled port1 level did not request wake");

    reset_zero_a: assert property (!$past(rstn) |-> (st.ie_main == REG_RESET)
        && (st.ie_ext == REG_RESET) && (st.prio_lo == REG_RESET)
        && (st.prio_hi == REG_RESET) && (st.polarity == REG_RESET))
        else $error("unit registers not zero after reset");

    read_answer_a: assert property (rd_take_s |=> st.rvalid ##0 !st.arready)
        else $error("read not answered in one cycle");

    // Masters wait on bvalid, so the answer cycle is pinned here
    write_answer_a: assert property (wr_fire_s |=> st.bvalid ##0 !st.awready ##0 !st.wready)
        else $error("write not answered one cycle after both halves");

    // Level offered must be the winner's own programmed level
    level_match_a: assert property (st.irq.req |-> st.irq.level == lvl_q[st.win_idx])
        else $error("request level differs from winner priority");

    // Return from the routine frees the high level first
    done_free_a: assert property (done_high_s |=> !st.in_service[1])
        else $error("end of service left high level marked");

    // Unused bits never read back as ones
    spare_zero_a: assert property (!st.ie_main[6] && (st.prio_lo[7:6] == 2'h0))
        else $error("unused enable or priority bit set");

endmodule : fsiu_top

//--- fsiu_core_model.sv
// Purpose: Behavioural processor core that takes interrupt vectors.
// Assumes: Acknowledge is a one-cycle pulse given while the request stands.
// Notes:   Return from service is asked for by the bench, one pulse.
`timescale 1ns/100ps

module fsiu_core_model
    import fsiu_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  fsiu_irq_t       irq_out,
    input  wire logic       respond,
    input  wire logic [3:0] ack_delay,
    input  wire logic       ret_req,
    output logic            irq_ack,
    output logic            irq_done,
    output logic [15:0]     taken_vec,
    output logic [7:0]      taken_cnt
);
    logic [3:0] wait_cnt;

    // ********************************************************************
    // Vector fetch
    // ********************************************************************
    // Ack after ack_delay cycles, so prompt and slow cores can both be modelled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_ack   <= 1'b0;
            irq_done  <= 1'b0;
            wait_cnt  <= 4'h0;
            taken_vec <= 16'h0000;
            taken_cnt <= 8'h00;
        end else begin
            irq_ack  <= 1'b0;
            irq_done <= ret_req;
            if (irq_ack && irq_out.req) begin
                taken_vec <= irq_out.vector;
                taken_cnt <= taken_cnt + 8'h01;
            end
            if (respond && irq_out.req && !irq_ack) begin
                if (wait_cnt >= ack_delay) begin
                    irq_ack  <= 1'b1;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule : fsiu_core_model

//--- test_fourteen_source_interrupt_unit.sv
// Purpose: Self-checking bench of the fourteen source interrupt unit.
// Assumes: Pins idle high as with pull-ups; bready and rready held high.
// Notes:   Each scenario drives the unit and judges the result itself.
`timescale 1ns/100ps

module test_fourteen_source_interrupt_unit;
    import fsiu_pkg::*;

    logic        sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr, p1_pins, taken_cnt, em, ex;
    logic [31:0] wdata, rdata;
    logic        awready, wready, bvalid, arready, rvalid, saw_wake;
    logic [1:0]  bresp, rresp;
    logic        x0_n, x1_n, idle_mode, respond, ret_req;
    logic        irq_ack, irq_done, wake_idle, wake_pd;
    logic [3:0]  ack_delay;
    logic [15:0] taken_vec;
    fsiu_src_t   core_flags;
    fsiu_irq_t   irq_out;
    int          num_errors, n_compared;

    // Winning order: bit 3 picks the extended enable, bits 2:0 the bit
    localparam logic [3:0] ORD [14] = '{4'h0, 4'h4, 4'hB, 4'h1, 4'hC, 4'h2, 4'h8,
                                        4'hD, 4'h3, 4'h5, 4'h9, 4'hE, 4'hA, 4'hF};

    fsiu_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_input_zero_n(x0_n), .ext_input_one_n(x1_n),
        .port1_ext_inputs(p1_pins), .core_flags(core_flags), .irq_ack(irq_ack),
        .irq_done(irq_done), .idle_mode(idle_mode), .irq_out(irq_out),
        .wake_idle(wake_idle), .wake_power_down(wake_pd));

    fsiu_core_model core_u (.sys_clk(sys_clk), .rstn(rstn), .irq_out(irq_out),
        .respond(respond), .ack_delay(ack_delay), .ret_req(ret_req), .irq_ack(irq_ack),
        .irq_done(irq_done), .taken_vec(taken_vec), .taken_cnt(taken_cnt));

    // ********************************************************************
    // Clock, watchdog and shared tasks
    // ********************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Whole run needs a few hundred cycles; 20000 cycles means a hang
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end

    // Wake to idle is a short pulse, so it is caught here
    always @(posedge sys_clk) if (wake_idle === 1'b1) saw_wake <= 1'b1;

    task automatic end_sim;
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // Vector from the enable position: 8-byte steps from 0003, port1 after slot 6
    function automatic logic [15:0] slot_vec(input logic [3:0] s);
        slot_vec = 16'h0003 + {9'h000, s[3] ? 4'h7 + {1'b0, s[2:0]} : {1'b0, s[2:0]}, 3'h0};
    endfunction : slot_vec

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        check({bvalid, bresp}, {1'b1, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        check({rvalid, rresp, rdata}, {1'b1, er, 24'h000000, ed});
    endtask : rd

    // Bounded wait for one given request, then compare level and vector
    task automatic wait_vec(input logic [15:0] v, input logic lv);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(irq_out.req === 1'b1 && irq_out.vector === v) && n < 40);
        check({irq_out.req, irq_out.level, irq_out.vector}, {1'b1, lv, v});
    endtask : wait_vec

    task automatic wait_taken(input logic [7:0] k);
        int n;
        n = 0;
        while (taken_cnt !== k && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        check(taken_cnt, k);
    endtask : wait_taken

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_regs;
        logic [7:0] amap [7];
        amap = '{ADDR_IE_MAIN, ADDR_IE_EXT, ADDR_PRIO_LO, ADDR_PRIO_HI, ADDR_FLAGS,
                 ADDR_POL, ADDR_STATUS};
        foreach (amap[i]) rd(amap[i], REG_RESET, RESP_OKAY);
        wr(ADDR_IE_MAIN, 8'hFF, RESP_OKAY);
        rd(ADDR_IE_MAIN, 8'hBF, RESP_OKAY);
        wr(ADDR_PRIO_LO, 8'hFF, RESP_OKAY);
        rd(ADDR_PRIO_LO, 8'h3F, RESP_OKAY);
        wr(ADDR_IE_MAIN, 8'h00, RESP_OKAY);
        wr(ADDR_PRIO_LO, 8'h00, RESP_OKAY);
        wr(8'hD0, 8'h55, RESP_SLVERR);
        rd(8'hD0, 8'h00, RESP_SLVERR);
    endtask : t_regs

    // All fourteen pending at one level; retire winners one by one
    task automatic t_order;
        logic seen;
        x0_n       <= 1'b0;
        x1_n       <= 1'b0;
        core_flags <= '1;
        wr(ADDR_POL, 8'hFF, RESP_OKAY);
        em = 8'h3F;
        ex = 8'hFF;
        wr(ADDR_IE_EXT, ex, RESP_OKAY);
        wr(ADDR_IE_MAIN, em, RESP_OKAY);
        seen = 1'b0;
        repeat (20) @(posedge sys_clk) seen |= irq_out.req;
        check(seen, 1'b0);
        em[GATE_BIT] = 1'b1;
        wr(ADDR_IE_MAIN, em, RESP_OKAY);
        for (int i = 0; i < NSRC; i++) begin
            wait_vec(slot_vec(ORD[i]), 1'b0);
            if (ORD[i][3]) ex[ORD[i][2:0]] = 1'b0;
            else em[ORD[i][2:0]] = 1'b0;
            wr(ORD[i][3] ? ADDR_IE_EXT : ADDR_IE_MAIN, ORD[i][3] ? ex : em, RESP_OKAY);
        end
        seen = 1'b0;
        repeat (10) @(posedge sys_clk) seen |= irq_out.req;
        check(seen, 1'b0);
    endtask : t_order

    // Priority beats order; serial by transmit and timer 2 by external flag
    task automatic t_prio;
        core_flags <= fsiu_src_t'(6'h11);
        wr(ADDR_PRIO_HI, 8'h80, RESP_OKAY);
        wr(ADDR_IE_EXT, 8'hFF, RESP_OKAY);
        wr(ADDR_IE_MAIN, 8'hBF, RESP_OKAY);
        wait_vec(16'h0073, 1'b1);
        wr(ADDR_PRIO_HI, 8'h00, RESP_OKAY);
        wr(ADDR_PRIO_LO, 8'h20, RESP_OKAY);
        wait_vec(16'h002B, 1'b1);
        wr(ADDR_PRIO_LO, 8'h10, RESP_OKAY);
        wait_vec(16'h0023, 1'b1);
        wr(ADDR_PRIO_LO, 8'h00, RESP_OKAY);
        wait_vec(16'h0003, 1'b0);
        x0_n       <= 1'b1;
        x1_n       <= 1'b1;
        core_flags <= '0;
        wr(ADDR_IE_MAIN, 8'h00, RESP_OKAY);
        wr(ADDR_IE_EXT, 8'h00, RESP_OKAY);
        wr(ADDR_POL, 8'h00, RESP_OKAY);
        wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
        rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
    endtask : t_prio

    // Active-low pulse on input five at high level, served twice until cleared
    task automatic t_service;
        idle_mode <= 1'b1;
        respond   <= 1'b1;
        ack_delay <= 4'h2;
        wr(ADDR_PRIO_HI, 8'h08, RESP_OKAY);
        wr(ADDR_IE_EXT, 8'h08, RESP_OKAY);
        wr(ADDR_IE_MAIN, 8'h80, RESP_OKAY);
        p1_pins <= 8'hF7;
        repeat (6) @(posedge sys_clk);
        check(wake_pd, 1'b1);
        p1_pins <= 8'hFF;
        rd(ADDR_FLAGS, 8'h08, RESP_OKAY);
        wait_taken(8'h01);
        check(taken_vec, 16'h0053);
        check(saw_wake, 1'b1);
        rd(ADDR_STATUS, 8'hA2, RESP_OKAY);
        ret_req <= 1'b1;
        @(posedge sys_clk) ret_req <= 1'b0;
        wait_taken(8'h02);
        wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
        ret_req <= 1'b1;
        @(posedge sys_clk) ret_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check({taken_cnt, irq_out.req}, {8'h02, 1'b0});
        respond   <= 1'b0;
        idle_mode <= 1'b0;
    endtask : t_service

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        num_errors = 0;
        n_compared = 0;
        rstn       = 1'b0;
        {awvalid, wvalid, arvalid, ret_req, respond, idle_mode, saw_wake} = 7'h00;
        {bready, rready, x0_n, x1_n} = 4'hF;
        {awaddr, araddr, wdata} = 48'h0;
        p1_pins    = 8'hFF;
        core_flags = '0;
        ack_delay  = 4'h0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_order();
        t_prio();
        t_service();
        end_sim();
    end
endmodule : test_fourteen_source_interrupt_unit
